// ===== rtl/adcc_top.sv
// Converter control block with AXI4-Lite register slave
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1: Control bits 7 and 6 show result bits 1 and 0.
// R2: With external enable 0 only a software start bit write starts.
// R3: With external enable 1 a pin rising edge also starts.
// R4: Done flag sets when result is ready and raises an interrupt if enabled.
// R5: Software clears the done flag; writing it to one is ignored.
// R6: No conversion begins while the done flag is one.
// R7: Start bit high through busy, cleared as done flag sets.
// R8: Writing zero to start bit is ignored; starts blocked while it is high.
// R9: Done and start bits together report idle, busy or completed.
// R10: Clearing done and setting start in one write may start a conversion.
// R11: Three channel bits select one of eight analog inputs.
// R12: Each conversion yields ten bits and ends fifty machine cycles later.
// R13: Converter runs only while its power enable is set.
// R14: External pin is synchronised and its rising edge gives one pulse.
module adcc_top #(
  parameter int CONV_CLKS = adcc_pkg::CONV_CLKS
) (
  input wire logic clk,
  input wire logic srst,
  // AXI4-Lite slave
  input wire logic [adcc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [adcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog core and pin
  input wire logic external_start_pin,
  input wire logic [adcc_pkg::RESULT_W-1:0] analog_result,
  output logic [adcc_pkg::CHAN_W-1:0] analog_channel,
  output logic converter_power_enable,
  output logic conv_start,
  output logic irq
);
  import adcc_pkg::*;

  // Elaboration check: the timer needs at least two clocks per conversion
  if (CONV_CLKS < 2) begin : g_conv_clks_check
    $error("CONV_CLKS too small");
  end

  // Map a byte address to a register index, or flag it unmapped
  // Bit 8 of the result marks a mapped, aligned address
  function automatic logic [8:0] decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [7:0] idx;
    idx = addr[9:2];
    decode = {1'b1, idx};
    if (addr[ADDR_W-1:10] != '0 || addr[1:0] != 2'h0) begin
      decode = 9'h000;
    end else if (idx != CTRL_IDX && idx != RESULT_IDX &&
                 idx != POWER_IDX && idx != IRQ_STATUS_IDX &&
                 idx != IRQ_MASK_IDX) begin
      decode = 9'h000;
    end
  endfunction

  // True when a decoded write hits the low byte of the given register
  function automatic logic wr_hit(
    input logic [8:0] dec,
    input logic [7:0] idx,
    input logic strb0
  );
    wr_hit = dec[8] & (dec[7:0] == idx) & strb0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic ext_en;
  logic done_flag;
  logic [CHAN_W-1:0] channel;
  logic [RESULT_W-1:0] result;
  logic power;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic busy;
  logic finish;
  logic pin_rise;

  // Write channel holding registers
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  adcc_edge u_edge (
    .clk(clk),
    .srst(srst),
    .pin(external_start_pin),
    .rise(pin_rise)
  );

  // Accepted start, one cycle wide; the timer ignores it while busy
  logic go;

  adcc_seq #(
    .CONV_CLKS(CONV_CLKS)
  ) u_seq (
    .clk(clk),
    .srst(srst),
    .go(go),
    .power(power),
    .busy(busy),
    .finish(finish),
    .conv_start(conv_start)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  logic do_write;
  logic [8:0] wdec;
  logic ctrl_wr;
  logic power_wr;
  logic status_wr;
  logic mask_wr;
  logic [7:0] wbyte;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wdec = decode(aw_addr);
  assign wbyte = w_data[7:0];
  // One strobe per writable register; a cleared byte strobe leaves it untouched
  assign ctrl_wr = do_write & wr_hit(wdec, CTRL_IDX, w_strb[0]);
  assign power_wr = do_write & wr_hit(wdec, POWER_IDX, w_strb[0]);
  assign status_wr = do_write & wr_hit(wdec, IRQ_STATUS_IDX, w_strb[0]);
  assign mask_wr = do_write & wr_hit(wdec, IRQ_MASK_IDX, w_strb[0]);

  // Start sources and acceptance
  logic sw_start;
  logic hw_start;
  logic done_clear;
  assign sw_start = ctrl_wr & wbyte[START_BIT]; // R8
  assign hw_start = ext_en & pin_rise; // R2 R3
  // A write of zero to the done bit clears it, but never in the cycle that
  // the conversion finishes: the hardware set must not be lost
  assign done_clear = ctrl_wr & ~wbyte[DONE_BIT] & ~finish;
  // Done must be clear, or cleared by this same write
  assign go = (sw_start | hw_start) & ~busy & power &
              (~done_flag | done_clear); // R6 R8 R10 R13

  ////////////////////////////////////////////////////////////////////////////
  // Channel value after this cycle's control write, if any
  logic [CHAN_W-1:0] next_channel;
  assign next_channel = ctrl_wr ? wbyte[CHAN_MSB:0] : channel;

  // Control fields
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_en <= CTRL_RESET[EXT_EN_BIT];
      channel <= CTRL_RESET[CHAN_MSB:0];
    end else if (ctrl_wr) begin
      ext_en <= wbyte[EXT_EN_BIT];
      channel <= wbyte[CHAN_MSB:0];
    end
  end

  // Done flag: hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      done_flag <= CTRL_RESET[DONE_BIT];
    end else if (finish) begin
      done_flag <= 1'b1; // R4 R7
    end else if (done_clear) begin
      done_flag <= 1'b0; // R5
    end
  end

  // Result capture at the end of conversion
  always_ff @(posedge clk) begin
    if (srst) begin
      result <= '0;
    end else if (finish) begin
      result <= analog_result; // R12
    end
  end

  // Power enable register
  always_ff @(posedge clk) begin
    if (srst) begin
      power <= POWER_RESET;
    end else if (power_wr) begin
      power <= wbyte[0]; // R13
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_events = {hw_start & go, finish};
  assign irq_clr = status_wr ? wbyte[IRQ_W-1:0] : '0;
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_status <= '0;
    end else begin
      irq_status <= irq_events | (irq_status & ~irq_clr);
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_mask <= IRQ_MASK_RESET;
    end else if (mask_wr) begin
      irq_mask <= wbyte[IRQ_W-1:0];
    end
  end

  // Interrupt output, one flop behind status
  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask); // R4
    end
  end

  // Analog-side outputs. The mux select moves on the same edge as the start
  // strobe, so a write that picks a channel and starts converts that channel
  always_ff @(posedge clk) begin
    if (srst) begin
      analog_channel <= CTRL_RESET[CHAN_MSB:0];
      converter_power_enable <= POWER_RESET;
    end else begin
      analog_channel <= next_channel; // R11
      converter_power_enable <= power; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channels, taken in either order
  // Each is held until the write is done and reopens after the response
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_bvalid;
    end
  end

  // Write data channel, mirror of the address channel
  always_ff @(posedge clk) begin
    if (srst) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else begin
      s_axi_wready <= ~w_held & ~s_axi_bvalid;
    end
  end

  // Write response
  // Stands until bready; unmapped or misaligned writes answer DECERR
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wdec[8] ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [8:0] rdec;
  logic [31:0] rword;
  logic [7:0] ctrl_view;
  assign rdec = decode(s_axi_araddr);
  // Status view: done and start bits together give converter state
  assign ctrl_view = {result[1], result[0], ext_en, done_flag, busy,
                      channel}; // R1 R9

  // Read mux; unmapped addresses are zeroed at the handshake
  always_comb begin
    rword = 32'h0000_0000;
    if (rdec[7:0] == CTRL_IDX) begin
      rword[7:0] = ctrl_view;
    end else if (rdec[7:0] == RESULT_IDX) begin
      rword[RESULT_W-1:0] = result;
    end else if (rdec[7:0] == POWER_IDX) begin
      rword[0] = power;
    end else if (rdec[7:0] == IRQ_STATUS_IDX) begin
      rword[IRQ_W-1:0] = irq_status;
    end else if (rdec[7:0] == IRQ_MASK_IDX) begin
      rword[IRQ_W-1:0] = irq_mask;
    end
  end

  // Read channel: data comes from the address seen at the handshake
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdec[8] ? rword : 32'h0000_0000;
      s_axi_rresp <= rdec[8] ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/adcc_pkg.sv
// Shared constants for the converter control block
package adcc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'hE1;
  localparam logic [7:0] RESULT_IDX = 8'hE2;
  localparam logic [7:0] POWER_IDX = 8'hE3;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'hE4;
  localparam logic [7:0] IRQ_MASK_IDX = 8'hE5;
  localparam int ADDR_W = 12;
  // Control/status field positions
  localparam int RES1_BIT = 7;
  localparam int RES0_BIT = 6;
  localparam int EXT_EN_BIT = 5;
  localparam int DONE_BIT = 4;
  localparam int START_BIT = 3;
  localparam int CHAN_MSB = 2;
  localparam int CHAN_W = 3;
  localparam int RESULT_W = 10;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_EXT_BIT = 1;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic POWER_RESET = 1'b1;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  // Timing
  localparam int CONV_MACHINE_CYCLES = 50;
  localparam int CLKS_PER_MACHINE_CYCLE = 4;
  localparam int CONV_CLKS = CONV_MACHINE_CYCLES * CLKS_PER_MACHINE_CYCLE;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ===== rtl/adcc_edge.sv
// Pin synchroniser with rising-edge pulse
`timescale 1ns/1ns
`default_nettype none
module adcc_edge (
  input wire logic clk,
  input wire logic srst,
  input wire logic pin,
  output logic rise
);
  logic meta;
  logic sync;
  logic prev;

  // Two-flop synchroniser, then compare with previous level
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
      rise <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
      rise <= sync & ~prev; // R14
    end
  end
endmodule
`default_nettype wire

// ===== rtl/adcc_seq.sv
// Conversion timer: busy interval and finish pulse
`timescale 1ns/1ns
`default_nettype none
module adcc_seq #(
  parameter int CONV_CLKS = 200
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic go,
  input wire logic power,
  output logic busy,
  output logic finish,
  output logic conv_start
);
  localparam int CW = $clog2(CONV_CLKS + 1);
  localparam logic [CW-1:0] LAST = CW'(CONV_CLKS - 1);
  logic [CW-1:0] count;

  // Elaboration check: the finish compare needs at least two clocks
  if (CONV_CLKS < 2) begin : g_conv_clks_check
    $error("CONV_CLKS must be at least 2");
  end

  // Busy spans the whole conversion; finish is its last cycle
  always_ff @(posedge clk) begin
    if (srst || !power) begin
      busy <= 1'b0;
      finish <= 1'b0;
      count <= '0;
    end else if (finish) begin
      busy <= 1'b0;
      finish <= 1'b0;
      count <= '0;
    end else if (busy) begin
      count <= count + CW'(1);
      finish <= (count == LAST - CW'(1)); // R12
    end else if (go) begin
      busy <= 1'b1; // R7
      count <= '0;
    end
  end

  // Start strobe to the analog core
  always_ff @(posedge clk) begin
    if (srst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= go & ~busy & power;
    end
  end
endmodule
`default_nettype wire

// ===== verif/adcc_analog_model.sv
// Behavioural model of the analog converter core
`timescale 1ns/1ns
`default_nettype none
module adcc_analog_model (
  input wire logic clk,
  input wire logic conv_start,
  input wire logic [adcc_pkg::CHAN_W-1:0] analog_channel,
  output logic [adcc_pkg::RESULT_W-1:0] analog_result
);
  import adcc_pkg::*;
  // Each start samples the selected input; value encodes the channel
  always_ff @(posedge clk) begin
    if (conv_start) begin
      analog_result <= {analog_channel, 7'h2D};
    end
  end
endmodule
`default_nettype wire

// ===== verif/adcc_top_sva.sv
// Port-level checker for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adcc_top_sva #(
  parameter int CONV_CLKS = 200
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [adcc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [adcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic converter_power_enable,
  input wire logic conv_start,
  input wire logic irq
);
  import adcc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_pulse; conv_start |=> !conv_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start not one cycle");
  property p_block; conv_start |=> !conv_start [*8]; endproperty
  a_block: assert property (p_block) else $error("start while busy");
  property p_power; !converter_power_enable |-> !conv_start; endproperty
  a_power: assert property (p_power) else $error("start unpowered");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_dec;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
      |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0;
  endproperty
  a_dec: assert property (p_dec) else $error("bad read not refused");
  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("no write answer");
  property p_bsy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bsy: assert property (p_bsy) else $error("ready during answer");
  property p_rend; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rend: assert property (p_rend) else $error("read answer stuck");
endmodule
bind adcc_top adcc_top_sva #(.CONV_CLKS(CONV_CLKS)) u_sva (
  .clk(clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .converter_power_enable(converter_power_enable),
  .conv_start(conv_start), .irq(irq)
);
`default_nettype wire

// ===== verif/adcc_top_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adcc_top_bench;
  import adcc_pkg::*;
  localparam int CC = 10;
  localparam logic [11:0] A_CTL = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] A_RES = {2'h0, RESULT_IDX, 2'h0};
  localparam logic [11:0] A_PWR = {2'h0, POWER_IDX, 2'h0};
  localparam logic [11:0] A_STS = {2'h0, IRQ_STATUS_IDX, 2'h0};
  localparam logic [11:0] A_MSK = {2'h0, IRQ_MASK_IDX, 2'h0};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, external_start_pin = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, conv_start, irq, converter_power_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [9:0] analog_result;
  logic [2:0] analog_channel;
  int mismatches = 0, compares = 0, cyc = 0;
  // Address, expected data, expected response
  logic [45:0] rows [7] = '{{A_CTL, 32'h0, 2'h0}, {A_RES, 32'h0, 2'h0},
    {A_PWR, 32'h1, 2'h0}, {A_STS, 32'h0, 2'h0}, {A_MSK, 32'h0, 2'h0},
    {12'h398, 32'h0, 2'h3}, {12'h385, 32'h0, 2'h3}};
  adcc_top #(.CONV_CLKS(CC)) u_dut (
    .clk(clk), .srst(srst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .external_start_pin(external_start_pin),
    .analog_result(analog_result), .analog_channel(analog_channel),
    .converter_power_enable(converter_power_enable),
    .conv_start(conv_start), .irq(irq)
  );
  adcc_analog_model u_model (
    .clk(clk), .conv_start(conv_start), .analog_channel(analog_channel),
    .analog_result(analog_result)
  );
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  // Shared bus and checking tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && s_axi_awready === 1) begin
        ta = 1;
        s_axi_awvalid <= 0;
      end
      if (!tw && s_axi_wready === 1) begin
        tw = 1;
        s_axi_wvalid <= 0;
      end
    end
    while (s_axi_bvalid !== 1) @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (s_axi_arready !== 1);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (s_axi_rvalid !== 1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic pin_pulse();
    external_start_pin <= 1;
    repeat (6) @(posedge clk);
    external_start_pin <= 0;
    repeat (14) @(posedge clk);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    foreach (rows[i]) begin
      rd(rows[i][45:34]);
      chk(d, rows[i][33:2]);
      chk(r, rows[i][1:0]);
    end
    wr(12'h398, 32'hFF);
    chk(r, RESP_DECERR);
    wr(A_CTL, 32'h0B);
    rd(A_CTL);
    chk(d, 32'h0B);
    chk(analog_channel, 3'h3);
    wr(A_CTL, 32'h03);
    rd(A_CTL);
    chk(d, 32'h0B);
    repeat (CC + 4) @(posedge clk);
    rd(A_CTL);
    chk(d, 32'h53);
    rd(A_RES);
    chk(d, 32'h1AD);
    wr(A_CTL, 32'h1B);
    repeat (3) @(posedge clk);
    rd(A_CTL);
    chk(d, 32'h53);
    wr(A_CTL, 32'h0D);
    rd(A_CTL);
    chk(d, 32'h4D);
    repeat (CC + 4) @(posedge clk);
    rd(A_CTL);
    chk(d, 32'h55);
    chk(irq, 1'b0);
    wr(A_MSK, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr(A_STS, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(A_CTL, 32'h00);
    pin_pulse();
    rd(A_CTL);
    chk(d, 32'h40);
    wr(A_CTL, 32'h20);
    pin_pulse();
    rd(A_CTL);
    chk(d, 32'h70);
    rd(A_STS);
    chk(d, 32'h3);
    wr(A_CTL, 32'h20);
    wr(A_PWR, 32'h0);
    wr(A_CTL, 32'h08);
    repeat (CC + 4) @(posedge clk);
    rd(A_CTL);
    chk(d, 32'h40);
    chk(converter_power_enable, 1'b0);
    s_axi_wstrb <= 4'h0;
    wr(A_PWR, 32'h1);
    s_axi_wstrb <= 4'h1;
    chk(r, RESP_OKAY);
    rd(A_PWR);
    chk(d, 32'h0);
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    rd(A_CTL);
    chk(d, 32'h0);
    rd(A_PWR);
    chk(d, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
